// [shared/spi_ctrl_pkg.sv]
// shared constants and types for the serial master register-side control
package spi_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MASK    = 8'h14;
  localparam logic [7:0] OFF_RAW     = 8'h18;
  localparam logic [7:0] OFF_MASKED    = 8'h1c;
  localparam logic [7:0] OFF_CLEAR     = 8'h20;
  localparam logic [7:0] OFF_DMA       = 8'h24;
  localparam logic [7:0] OFF_RX_FRAMES = 8'h28;
  localparam logic [7:0] OFF_DUMMY     = 8'h2c;
  localparam logic [7:0] OFF_TX_FRAMES = 8'h30;
  localparam logic [7:0] OFF_PROGRESS  = 8'h34;
  localparam logic [7:0] OFF_TEST_CTRL = 8'h80;
  localparam logic [7:0] OFF_TEST_PORT = 8'h8c;
  // interrupt bit positions
  localparam int IRQ_W       = 6;
  localparam int BIT_ROR     = 0;
  localparam int BIT_RT      = 1;
  localparam int BIT_RX      = 2;
  localparam int BIT_TX      = 3;
  localparam int BIT_TUR     = 4;
  localparam int BIT_TE      = 5;
  // write-one clear positions
  localparam int CLR_ROR     = 0;
  localparam int CLR_RT      = 1;
  localparam int CLR_TUR     = 2;
  // dma control and test control positions
  localparam int BIT_RXDMA   = 0;
  localparam int BIT_TXDMA   = 2;
  localparam int BIT_SWAP    = 1;
  localparam int CNT_W       = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // interrupt sources from the shift engine and fifos
  typedef struct packed {
    logic te;
    logic tur;
    logic tx;
    logic rx;
    logic rt;
    logic ror;
  } irq_vec_s;
  // fifo access strobes toward the fifos
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [31:0] data;
  } fifo_req_s;
endpackage : spi_ctrl_pkg

// [hw/spi_irq_dma_fifo_ctrl.sv]
// register-side control: interrupts, dma requests, frame counts, fifo swap test port
`timescale 1ns/1ps
// Behaviour
// - masked status bits 0..5 are raw status ANDed with mask; upper bits zero.
// - mask bit one passes a source to the interrupt line, zero blocks it.
// - writing one to clear bit 0 clears receive overrun; zero does nothing.
// - writing one to clear bit 1 clears receive timeout.
// - writing one to clear bit 2 clears transmit underrun.
// - receive dma request only while dma control bit 0 is one.
// - transmit dma request only while dma control bit 2 is one; bit 1 reserved.
// - sixteen-bit read-write count of frames to receive from the slave.
// - sixteen-bit count of frames taken from the transmit fifo.
// - swap clear: test port write pushes transmit fifo, read pops receive fifo.
// - swap set: test port write pushes receive fifo, read pops transmit fifo.
// - thirty-two-bit test data port, reset zero, reads transmit fifo when swapped.
// - masked status resets to zero and is read-only.
module spi_irq_dma_fifo_ctrl #(
  parameter int FRAME_BITS = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite slave
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // events and live conditions from the shift engine and fifos
  input  wire spi_ctrl_pkg::irq_vec_s   irq_src,
  input  wire logic                     rx_not_empty,
  input  wire logic                     tx_not_empty,
  input  wire logic [31:0]              tx_head_data,
  input  wire logic [31:0]              rx_head_data,
  // fifo strobes
  output spi_ctrl_pkg::fifo_req_s       tx_fifo_req,
  output spi_ctrl_pkg::fifo_req_s       rx_fifo_req,
  // dma and interrupt
  output logic                          rx_dma_req,
  output logic                          tx_dma_req,
  output logic                          irq,
  // link pins seen by the block
  input  wire logic                     sck_pin,
  input  wire logic                     cs_pin_n,
  output logic                          send_dummy,
  output logic [31:0]                   dummy_character
);

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b01,
    LINK_FRAME = 2'b10
  } link_state_e;

  // register state
  logic [spi_ctrl_pkg::IRQ_W-1:0] irq_mask_set_reg;
  logic [spi_ctrl_pkg::IRQ_W-1:0] sticky_reg;
  logic [spi_ctrl_pkg::IRQ_W-1:0] raw_irq_status;
  logic [spi_ctrl_pkg::IRQ_W-1:0] masked_irq_status;
  logic                           rx_single_dma_enable_reg;
  logic                           tx_single_dma_enable_reg;
  logic [spi_ctrl_pkg::CNT_W-1:0] rx_frame_count_reg;
  logic [spi_ctrl_pkg::CNT_W-1:0] tx_fifo_frame_count_reg;
  logic [31:0]                    dummy_character_reg;
  logic                           fifo_path_swap_reg;
  logic [31:0]                    fifo_test_data_port_reg;
  logic [spi_ctrl_pkg::CNT_W-1:0] frames_left_reg;

  // bus handshake state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        aw_take;
  logic        w_take;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [31:0] wmerged;
  logic        port_wr;
  logic        port_rd;
  logic        port_wr_d_reg;
  logic [31:0] rx_count_merged;
  logic [31:0] tx_count_merged;

  // link sampling state
  logic [1:0]  sck_sync_reg;
  logic [1:0]  cs_sync_reg;
  logic        sck_last_reg;
  logic        sck_rise;
  logic [7:0]  bit_cnt_reg;
  link_state_e link_state_reg;

  // address decode, shared by read and write paths
  function automatic logic known_addr(input logic [7:0] a);
    case (a)
      spi_ctrl_pkg::OFF_MASK, spi_ctrl_pkg::OFF_RAW, spi_ctrl_pkg::OFF_MASKED,
      spi_ctrl_pkg::OFF_CLEAR, spi_ctrl_pkg::OFF_DMA, spi_ctrl_pkg::OFF_RX_FRAMES,
      spi_ctrl_pkg::OFF_DUMMY, spi_ctrl_pkg::OFF_TX_FRAMES, spi_ctrl_pkg::OFF_PROGRESS,
      spi_ctrl_pkg::OFF_TEST_CTRL, spi_ctrl_pkg::OFF_TEST_PORT: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction : known_addr

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // write channel: address and data taken independently, response after both
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit  = wr_fire && known_addr(waddr_reg);
  localparam logic [31:0] RESET_WORD_C = spi_ctrl_pkg::RESET_WORD;
  assign wmerged = merge(RESET_WORD_C, wdata_reg, wstrb_reg);
  // counts keep their old bytes where a lane is not strobed
  assign rx_count_merged = merge({16'h0000, rx_frame_count_reg}, wdata_reg, wstrb_reg);
  assign tx_count_merged = merge({16'h0000, tx_fifo_frame_count_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spi_ctrl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? spi_ctrl_pkg::RESP_OKAY : spi_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; reserved bits are simply not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_set_reg         <= '0;
      rx_single_dma_enable_reg <= 1'b0;
      tx_single_dma_enable_reg <= 1'b0;
      rx_frame_count_reg       <= '0;
      tx_fifo_frame_count_reg  <= '0;
      dummy_character_reg      <= 32'h0000_0000;
      fifo_path_swap_reg       <= 1'b0;
    end else if (wr_hit) begin
      case (waddr_reg)
        spi_ctrl_pkg::OFF_MASK:
          irq_mask_set_reg <= wmerged[spi_ctrl_pkg::IRQ_W-1:0];
        spi_ctrl_pkg::OFF_DMA: begin
          rx_single_dma_enable_reg <= wmerged[spi_ctrl_pkg::BIT_RXDMA];
          tx_single_dma_enable_reg <= wmerged[spi_ctrl_pkg::BIT_TXDMA];
        end
        spi_ctrl_pkg::OFF_RX_FRAMES:
          rx_frame_count_reg <= rx_count_merged[spi_ctrl_pkg::CNT_W-1:0];
        spi_ctrl_pkg::OFF_TX_FRAMES:
          tx_fifo_frame_count_reg <= tx_count_merged[spi_ctrl_pkg::CNT_W-1:0];
        spi_ctrl_pkg::OFF_DUMMY:
          dummy_character_reg <= merge(dummy_character_reg, wdata_reg, wstrb_reg);
        spi_ctrl_pkg::OFF_TEST_CTRL:
          fifo_path_swap_reg <= wmerged[spi_ctrl_pkg::BIT_SWAP];
        default: ;
      endcase
    end
  end

  // read channel: one read at a time, data registered
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hit  = rd_fire && known_addr(s_axi_araddr);
  assign port_rd = rd_hit && (s_axi_araddr == spi_ctrl_pkg::OFF_TEST_PORT);
  assign port_wr = wr_hit && (waddr_reg == spi_ctrl_pkg::OFF_TEST_PORT);

  // read mux; the test port read shows the head of the selected fifo
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      spi_ctrl_pkg::OFF_MASK:  rd_word[spi_ctrl_pkg::IRQ_W-1:0] = irq_mask_set_reg;
      spi_ctrl_pkg::OFF_RAW:   rd_word[spi_ctrl_pkg::IRQ_W-1:0] = raw_irq_status;
      spi_ctrl_pkg::OFF_MASKED: rd_word[spi_ctrl_pkg::IRQ_W-1:0] = masked_irq_status;
      spi_ctrl_pkg::OFF_DMA: begin
        rd_word[spi_ctrl_pkg::BIT_RXDMA] = rx_single_dma_enable_reg;
        rd_word[spi_ctrl_pkg::BIT_TXDMA] = tx_single_dma_enable_reg;
      end
      spi_ctrl_pkg::OFF_RX_FRAMES: rd_word[spi_ctrl_pkg::CNT_W-1:0] = rx_frame_count_reg;
      spi_ctrl_pkg::OFF_DUMMY: rd_word = dummy_character_reg;
      spi_ctrl_pkg::OFF_TX_FRAMES: rd_word[spi_ctrl_pkg::CNT_W-1:0] = tx_fifo_frame_count_reg;
      spi_ctrl_pkg::OFF_PROGRESS: rd_word[spi_ctrl_pkg::CNT_W-1:0] = frames_left_reg;
      spi_ctrl_pkg::OFF_TEST_CTRL: rd_word[spi_ctrl_pkg::BIT_SWAP] = fifo_path_swap_reg;
      spi_ctrl_pkg::OFF_TEST_PORT: rd_word = fifo_path_swap_reg ? tx_head_data
                                                                : rx_head_data;
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= spi_ctrl_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? spi_ctrl_pkg::RESP_OKAY : spi_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // test port: direction of push and pop follows the swap bit
  always_comb begin
    tx_fifo_req      = '0;
    rx_fifo_req      = '0;
    tx_fifo_req.data = fifo_test_data_port_reg;
    rx_fifo_req.data = fifo_test_data_port_reg;
    if (fifo_path_swap_reg) begin
      rx_fifo_req.push = port_wr_d_reg;
      tx_fifo_req.pop  = port_rd && tx_not_empty;
    end else begin
      tx_fifo_req.push = port_wr_d_reg;
      rx_fifo_req.pop  = port_rd && rx_not_empty;
    end
  end

  // push lags the write by a cycle so the data comes from the held register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_wr_d_reg           <= 1'b0;
      fifo_test_data_port_reg <= 32'h0000_0000;
    end else begin
      port_wr_d_reg <= port_wr;
      if (port_wr) begin
        fifo_test_data_port_reg <= merge(fifo_test_data_port_reg, wdata_reg, wstrb_reg);
      end else if (port_rd) begin
        fifo_test_data_port_reg <= rd_word;
      end
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_reg <= '0;
    end else begin
      for (int i = 0; i < spi_ctrl_pkg::IRQ_W; i++) begin
        if (irq_src[i]) begin
          sticky_reg[i] <= 1'b1;
        end
      end
      if (wr_hit && waddr_reg == spi_ctrl_pkg::OFF_CLEAR) begin
        if (wmerged[spi_ctrl_pkg::CLR_ROR] && !irq_src.ror)
          sticky_reg[spi_ctrl_pkg::BIT_ROR] <= 1'b0;
        if (wmerged[spi_ctrl_pkg::CLR_RT] && !irq_src.rt)
          sticky_reg[spi_ctrl_pkg::BIT_RT] <= 1'b0;
        if (wmerged[spi_ctrl_pkg::CLR_TUR] && !irq_src.tur)
          sticky_reg[spi_ctrl_pkg::BIT_TUR] <= 1'b0;
      end
    end
  end

  // level sources pass straight through; only three bits are sticky
  always_comb begin
    raw_irq_status = sticky_reg;
    raw_irq_status[spi_ctrl_pkg::BIT_RX] = irq_src.rx;
    raw_irq_status[spi_ctrl_pkg::BIT_TX] = irq_src.tx;
    raw_irq_status[spi_ctrl_pkg::BIT_TE] = irq_src.te;
  end
  assign masked_irq_status = raw_irq_status & irq_mask_set_reg;
  assign irq = |masked_irq_status;

  // single dma requests gated by their enables
  assign rx_dma_req = rx_single_dma_enable_reg && rx_not_empty;
  assign tx_dma_req = tx_single_dma_enable_reg && irq_src.tx;

  // link pins are asynchronous: two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync_reg <= 2'b00;
      cs_sync_reg  <= 2'b11;
      sck_last_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck_pin};
      cs_sync_reg  <= {cs_sync_reg[0], cs_pin_n};
      sck_last_reg <= sck_sync_reg[1];
    end
  end
  assign sck_rise = sck_sync_reg[1] && !sck_last_reg;

  // frame counting; remaining receive frames reload at each select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_state_reg  <= LINK_IDLE;
      bit_cnt_reg     <= 8'h00;
      frames_left_reg <= '0;
    end else begin
      unique case (link_state_reg)
        LINK_IDLE: begin
          bit_cnt_reg <= 8'h00;
          if (!cs_sync_reg[1]) begin
            link_state_reg  <= LINK_FRAME;
            frames_left_reg <= rx_frame_count_reg;
          end
        end
        LINK_FRAME: begin
          if (cs_sync_reg[1]) begin
            link_state_reg <= LINK_IDLE;
          end else if (sck_rise) begin
            if (bit_cnt_reg == 8'(FRAME_BITS - 1)) begin
              bit_cnt_reg <= 8'h00;
              if (frames_left_reg != '0) begin
                frames_left_reg <= frames_left_reg - 1'b1;
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // dummy word goes out when receive frames remain but nothing is queued
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_dummy      <= 1'b0;
      dummy_character <= 32'h0000_0000;
    end else begin
      send_dummy      <= (link_state_reg == LINK_FRAME) && (frames_left_reg != '0)
                         && !tx_not_empty;
      dummy_character <= dummy_character_reg;
    end
  end

  // assertions
  sequence clear_ror_write;
    wr_hit && waddr_reg == spi_ctrl_pkg::OFF_CLEAR && wmerged[spi_ctrl_pkg::CLR_ROR]
      && !irq_src.ror;
  endsequence

  masked_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == spi_ctrl_pkg::OFF_MASKED
      |=> s_axi_rdata[31:spi_ctrl_pkg::IRQ_W] == '0)
    else $error("masked status upper bits not zero");
  status_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hit && waddr_reg == spi_ctrl_pkg::OFF_MASKED && !irq_src.ror && !irq_src.rt
      && !irq_src.tur
      |=> $stable(irq_mask_set_reg) && $stable(sticky_reg[spi_ctrl_pkg::BIT_ROR])
        && $stable(sticky_reg[spi_ctrl_pkg::BIT_RT]) && $stable(sticky_reg[spi_ctrl_pkg::BIT_TUR]))
    else $error("write to masked status changed state");
  irq_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_src.rx && irq_mask_set_reg[spi_ctrl_pkg::BIT_RX] |-> irq)
    else $error("unmasked source missing from irq");
  ror_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clear_ror_write |=> !raw_irq_status[spi_ctrl_pkg::BIT_ROR])
    else $error("overrun not cleared");
  rt_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_src.rt |=> raw_irq_status[spi_ctrl_pkg::BIT_RT])
    else $error("timeout event lost");
  tur_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    raw_irq_status[spi_ctrl_pkg::BIT_TUR] && !(wr_hit && waddr_reg == spi_ctrl_pkg::OFF_CLEAR)
      |=> raw_irq_status[spi_ctrl_pkg::BIT_TUR])
    else $error("underrun dropped without clear");
  rx_dma_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_single_dma_enable_reg |-> !rx_dma_req)
    else $error("rx dma request while disabled");
  tx_dma_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_dma_req |-> tx_single_dma_enable_reg)
    else $error("tx dma request while disabled");
  swap_pop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_fifo_req.pop |-> fifo_path_swap_reg && port_rd)
    else $error("tx fifo popped outside swap mode");
  norm_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    port_wr && !fifo_path_swap_reg |=> tx_fifo_req.push && !rx_fifo_req.push)
    else $error("normal mode write did not reach tx fifo");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response late");

endmodule : spi_irq_dma_fifo_ctrl

// [dv/spi_link_model.sv]
// behavioural serial slave side: frames of link clock pulses under select
`timescale 1ns/1ps
module spi_link_model (
  input  wire logic       go,
  input  wire logic [7:0] bits,
  output logic            sck_pin,
  output logic            cs_pin_n,
  output logic            busy
);
  initial begin
    sck_pin  = 1'b0;
    cs_pin_n = 1'b1;
    busy     = 1'b0;
  end
  // link clock only runs inside a frame; unrelated in phase to aclk
  always @(posedge go) begin
    busy = 1'b1;
    cs_pin_n = 1'b0;
    #137;
    repeat (bits) begin
      sck_pin = 1'b1;
      #160;
      sck_pin = 1'b0;
      #160;
    end
    #100;
    cs_pin_n = 1'b1;
    busy = 1'b0;
  end
endmodule : spi_link_model

// [dv/spi_irq_dma_fifo_ctrl_test.sv]
// self-checking bench for the register-side control block
`timescale 1ns/1ps
module spi_irq_dma_fifo_ctrl_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, rx_ne, tx_ne, rx_dma, tx_dma, irq, sck, cs_n;
  logic go, busy, send_dummy;
  logic [7:0]  awaddr, araddr, bits;
  logic [31:0] wdata, rdata, tx_head, rx_head, dummy, rd, last_push;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  strb;
  spi_ctrl_pkg::irq_vec_s  irq_src;
  spi_ctrl_pkg::fifo_req_s txq, rxq;
  int errors, check_count, cycles, tx_push, rx_push, tx_pop, rx_pop;

  spi_irq_dma_fifo_ctrl #(.FRAME_BITS(8)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_src(irq_src), .rx_not_empty(rx_ne), .tx_not_empty(tx_ne),
    .tx_head_data(tx_head), .rx_head_data(rx_head), .tx_fifo_req(txq), .rx_fifo_req(rxq),
    .rx_dma_req(rx_dma), .tx_dma_req(tx_dma), .irq(irq), .sck_pin(sck), .cs_pin_n(cs_n),
    .send_dummy(send_dummy), .dummy_character(dummy));
  spi_link_model link (.go(go), .bits(bits), .sck_pin(sck), .cs_pin_n(cs_n), .busy(busy));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // fifo strobe monitor; sampled mid-cycle so one-cycle pulses are settled
  always @(negedge aclk) begin
    cycles++;
    if (txq.push) begin tx_push++; last_push = txq.data; end
    if (rxq.push) begin rx_push++; last_push = rxq.data; end
    if (txq.pop) tx_pop++;
    if (rxq.pop) rx_pop++;
    if (cycles == 20000) begin errors++; end_sim(); end
  end

  task automatic end_sim();
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, s); end
  endtask : chk
  // ready is read mid-cycle, where it already holds its value for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk); ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rs = bresp;
      @(posedge aclk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk); ta = arvalid & arready; tr = rvalid; rd = rdata; rs = rresp;
      @(posedge aclk); if (ta) arvalid <= 1'b0;
    end while (!tr);
  endtask : rd_reg
  task automatic t_reset_values();
    logic [7:0] offs [7] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h80};
    foreach (offs[i]) begin rd_reg(offs[i]); chk("reset value", 32'h0, rd); end
    chk("dummy out", 32'h0, dummy);
    rd_reg(8'h8c); chk("test port reset", 32'h0, rd);
    rd_reg(8'h40); chk("unmapped resp", 32'h2, {30'h0, rs});
  endtask : t_reset_values
  task automatic t_irq();
    irq_src <= 6'h13;
    @(posedge aclk); irq_src <= 6'h2c;
    rd_reg(8'h1c); chk("masked off", 32'h0, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h14, 32'h3f); rd_reg(8'h1c); chk("masked all", 32'h3f, rd);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(8'h20, 32'h0); rd_reg(8'h1c); chk("clear zero", 32'h3f, rd);
    wr(8'h20, 32'h1); rd_reg(8'h1c); chk("clear ror", 32'h3e, rd);
    wr(8'h20, 32'h2); rd_reg(8'h1c); chk("clear rt", 32'h3c, rd);
    wr(8'h20, 32'h4); rd_reg(8'h1c); chk("clear tur", 32'h2c, rd);
    wr(8'h1c, 32'h0); rd_reg(8'h1c); chk("status ro", 32'h2c, rd);
    irq_src <= 6'h08; wr(8'h14, 32'h04); rd_reg(8'h1c); chk("level gone", 32'h0, rd);
    @(negedge aclk); chk("irq off", 32'h0, {31'h0, irq});
  endtask : t_irq
  task automatic t_dma();
    @(posedge aclk); rx_ne <= 1'b1;
    wr(8'h24, 32'h1); @(negedge aclk);
    chk("rx dma on", 32'h1, {31'h0, rx_dma});
    chk("tx dma off", 32'h0, {31'h0, tx_dma});
    @(posedge aclk); wr(8'h24, 32'h4); @(negedge aclk);
    chk("rx dma off", 32'h0, {31'h0, rx_dma});
    chk("tx dma on", 32'h1, {31'h0, tx_dma});
    @(posedge aclk); rd_reg(8'h24); chk("dma ctrl", 32'h4, rd);
  endtask : t_dma
  task automatic t_counts();
    wr(8'h28, 32'h0000ffff); rd_reg(8'h28); chk("rx frames", 32'hffff, rd);
    wr(8'h30, 32'h0000a5c3); rd_reg(8'h30); chk("tx frames", 32'ha5c3, rd);
    wr(8'h2c, 32'hdeadbeef); rd_reg(8'h2c); chk("dummy", 32'hdeadbeef, rd);
    chk("dummy out", 32'hdeadbeef, dummy);
    strb <= 4'h1; wr(8'h2c, 32'h00000012); strb <= 4'hf;
    rd_reg(8'h2c); chk("dummy lane", 32'hdeadbe12, rd);
    wr(8'h28, 32'h3); bits <= 8'h10; go <= 1'b1;
    @(posedge aclk); go <= 1'b0;
    repeat (60) @(posedge aclk);
    @(negedge aclk); chk("dummy in frame", 32'h1, {31'h0, send_dummy});
    repeat (140) @(posedge aclk);
    chk("link idle", 32'h0, {31'h0, busy});
    @(negedge aclk); chk("dummy idle", 32'h0, {31'h0, send_dummy});
    @(posedge aclk); rd_reg(8'h34); chk("frames left", 32'h1, rd);
  endtask : t_counts
  task automatic t_swap();
    rx_head <= 32'h0bad0001; tx_head <= 32'h0bad0002; tx_ne <= 1'b1;
    wr(8'h8c, 32'h11); @(posedge aclk);
    chk("tx push", 32'h1, tx_push); chk("push data", 32'h11, last_push);
    rd_reg(8'h8c); chk("rx head", 32'h0bad0001, rd); chk("rx pop", 32'h1, rx_pop);
    wr(8'h80, 32'h2); rd_reg(8'h80); chk("swap ctrl", 32'h2, rd);
    wr(8'h8c, 32'h22); @(posedge aclk);
    chk("rx push", 32'h1, rx_push); chk("push data", 32'h22, last_push);
    rd_reg(8'h8c); chk("tx head", 32'h0bad0002, rd);
    chk("tx pop", 32'h1, tx_pop);
    tx_ne <= 1'b0; rd_reg(8'h8c); chk("flush stops", 32'h1, tx_pop);
  endtask : t_swap

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_ne, tx_ne, go} = '0;
    {awaddr, araddr, bits, wdata, tx_head, rx_head} = '0;
    irq_src = '0;
    strb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_irq();
    t_dma();
    t_counts();
    t_swap();
    end_sim();
  end
endmodule : spi_irq_dma_fifo_ctrl_test
